/* File: rtl/smt_pkg.sv */
// constants shared by the stepper translator and its bridge current loops
package smt_pkg;

  // ***************************
  // clock and pwm timing
  // ***************************
  localparam int unsigned CLK_MHZ = 100;
  localparam logic [8:0] PWM_LAST = 9'h1ff;
  localparam logic [8:0] PWM_HALF = 9'h100;
  localparam logic [8:0] PWM_TOP_POINT = 9'h180;
  localparam int unsigned DEAD_TIME_NS = 100;
  localparam int unsigned SHORT_TIME_NS = 500;
  // least times round up, longest times round down
  localparam logic [5:0] DEAD_CYC = 6'((DEAD_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [5:0] SHORT_CYC = 6'((SHORT_TIME_NS * CLK_MHZ) / 1000);

  // ***************************
  // translator
  // ***************************
  localparam logic [6:0] IDX_RESET = 7'h10;
  localparam logic [2:0] RES_1_32 = 3'h0;
  localparam logic [2:0] RES_1_16 = 3'h1;
  localparam logic [2:0] RES_1_8 = 3'h2;
  localparam logic [2:0] RES_1_4 = 3'h3;
  localparam logic [2:0] RES_1_2 = 3'h4;

  // ***************************
  // gate patterns {hiA, loA, hiB, loB}
  // ***************************
  localparam logic [3:0] GATE_OFF = 4'h0;
  localparam logic [3:0] GATE_POS = 4'h9;
  localparam logic [3:0] GATE_NEG = 4'h6;
  localparam logic [3:0] GATE_SLOW = 4'h5;

  typedef enum logic {PH_FWD, PH_DECAY} smt_phase_e;

  // quarter cosine, 0..32 of a 128 step circle, full scale 8'hff
  function automatic logic [7:0] smt_cos_mag(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      6'h00: m = 8'hff;
      6'h01: m = 8'hff;
      6'h02: m = 8'hfe;
      6'h03: m = 8'hfc;
      6'h04: m = 8'hfa;
      6'h05: m = 8'hf7;
      6'h06: m = 8'hf4;
      6'h07: m = 8'hf0;
      6'h08: m = 8'hec;
      6'h09: m = 8'he7;
      6'h0a: m = 8'he1;
      6'h0b: m = 8'hdb;
      6'h0c: m = 8'hd4;
      6'h0d: m = 8'hcd;
      6'h0e: m = 8'hc5;
      6'h0f: m = 8'hbd;
      6'h10: m = 8'hb4;
      6'h11: m = 8'hab;
      6'h12: m = 8'ha2;
      6'h13: m = 8'h98;
      6'h14: m = 8'h8e;
      6'h15: m = 8'h83;
      6'h16: m = 8'h78;
      6'h17: m = 8'h6d;
      6'h18: m = 8'h62;
      6'h19: m = 8'h56;
      6'h1a: m = 8'h4a;
      6'h1b: m = 8'h3e;
      6'h1c: m = 8'h32;
      6'h1d: m = 8'h25;
      6'h1e: m = 8'h19;
      6'h1f: m = 8'h0c;
      default: m = 8'h00;
    endcase
    return m;
  endfunction : smt_cos_mag

endpackage : smt_pkg

/* File: rtl/smt_translator_pwm.sv */
// step translator and two per-bridge pwm current loops
//
// Contract
// - pwm switching points fall on the free-running internal pwm counter
// - pwm period is a fixed constant, no input changes it
// - applied duty cycle measured per bridge and held in a status output
// - dead time keeps high and low switch of a half-bridge never both on
// - two-bit slope setting from control register 3 drives slope output
// - switch with overvoltage longer than transition time is turned off
// - drive enable low: bridges high impedance, pwm stops, translator still runs
// - drive enable high: regulation restarts at current translator position
// - forward plus slow decay normally, fast decay when setpoint steps lower
// - setpoint not reached by 75% of period: top regulation, duty above 50%
// - top or bottom regulation flag reported per winding
// - effective resolution is register field plus binary value of two pins; here sums above 4 saturate at 1/2
// - resolution codes 0..4 select 1/32, 1/16, 1/8, 1/4, 1/2 stepping
// - after reset: 1/32 stepping at index 16, both coils 70.7%
// - in 1/32 mode each step moves the index by one per direction
// - coarser resolution clears low bits, snapping toward rotation direction
// - finer resolution keeps the index, low bits simply zero
// - resolution changes act only at the next step pulse or command
// - index maps to signed cosine X and sine Y currents, wraps after 127
// - direction and run/hold come from pins or register bits
`timescale 1ns/10ps

// ***************************
// one h-bridge current loop
// ***************************
module smt_bridge
  import smt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic setNeg,
  input wire logic lowerReq,
  input wire logic reached,
  input wire logic [3:0] overVolt,
  input wire logic [8:0] pwmCnt,
  output logic [3:0] gate_q,
  output logic off_q,
  output logic [7:0] duty_q,
  output logic topReg_q,
  output logic fastDecay_q,
  output logic shortFault_q
);
  smt_phase_e phase_q;
  logic [9:0] fwdCnt_q;
  logic [5:0] deadCnt_q;
  logic [5:0] shortCnt_q;
  logic [3:0] gate_d;
  logic run;
  logic periodEnd;
  assign run = enable & ~shortFault_q;
  assign periodEnd = (pwmCnt == PWM_LAST);
  // phase: forward from each period start until the comparator trips, in top regulation not before the half period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= PH_DECAY;
    end else if (!run) begin
      phase_q <= PH_DECAY;
    end else if (periodEnd) begin
      phase_q <= PH_FWD;
    end else if (phase_q == PH_FWD && reached && (!topReg_q || pwmCnt > PWM_HALF)) begin
      phase_q <= PH_DECAY;
    end
  end
  // top regulation entered when forward still runs at 75% of the period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      topReg_q <= 1'b0;
    end else if (phase_q == PH_FWD && pwmCnt == PWM_TOP_POINT && run) begin
      topReg_q <= 1'b1;
    end else if (phase_q == PH_FWD && reached && pwmCnt < PWM_HALF) begin
      topReg_q <= 1'b0;
    end
  end
  // fast decay armed by a lower setpoint, kept for the rest of the period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fastDecay_q <= 1'b0;
    end else if (lowerReq) begin
      fastDecay_q <= 1'b1;
    end else if (periodEnd) begin
      fastDecay_q <= 1'b0;
    end
  end
  // duty measured as forward cycles per period, latched at period end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fwdCnt_q <= 10'h000;
      duty_q <= 8'h00;
    end else if (periodEnd) begin
      fwdCnt_q <= 10'h000;
      duty_q <= fwdCnt_q[9] ? 8'hff : fwdCnt_q[8:1];
    end else if (phase_q == PH_FWD && run) begin
      fwdCnt_q <= fwdCnt_q + 10'h001;
    end
  end
  always_comb begin
    gate_d = GATE_OFF;
    if (run) begin
      if (phase_q == PH_FWD) begin
        gate_d = setNeg ? GATE_NEG : GATE_POS;
      end else if (fastDecay_q) begin
        gate_d = setNeg ? GATE_POS : GATE_NEG;
      end else begin
        gate_d = GATE_SLOW;
      end
    end
  end
  // switches turn off at once, turn on only after the dead time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_q <= GATE_OFF;
      deadCnt_q <= 6'h00;
    end else if (!run) begin
      gate_q <= GATE_OFF;
      deadCnt_q <= DEAD_CYC;
    end else if (gate_q != gate_d) begin
      if ((gate_q & ~gate_d) != 4'h0) begin
        gate_q <= gate_q & gate_d;
        deadCnt_q <= DEAD_CYC;
      end else if (deadCnt_q == 6'h00) begin
        gate_q <= gate_d;
      end else begin
        deadCnt_q <= deadCnt_q - 6'h01;
      end
    end else if (deadCnt_q != 6'h00) begin
      deadCnt_q <= deadCnt_q - 6'h01;
    end
  end
  // short guard; fault holds until the drive enable is dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shortCnt_q <= 6'h00;
      shortFault_q <= 1'b0;
    end else begin
      if ((gate_q & overVolt) != 4'h0) begin
        shortCnt_q <= (shortCnt_q == SHORT_CYC) ? shortCnt_q : shortCnt_q + 6'h01;
      end else begin
        shortCnt_q <= 6'h00;
      end
      if (shortCnt_q == SHORT_CYC) begin
        shortFault_q <= 1'b1;
      end else if (!enable) begin
        shortFault_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      off_q <= 1'b1;
    end else begin
      off_q <= ~run;
    end
  end
endmodule : smt_bridge

// ***************************
// translator top
// ***************************
module smt_translator_pwm
  import smt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic stepPulseIn,
  input wire logic stepAdvanceCmd,
  input wire logic rotationSensePin,
  input wire logic rotationSenseBit,
  input wire logic ctrlFromBits,
  input wire logic runHoldIn,
  input wire logic runHoldBit,
  input wire logic resPinLo,
  input wire logic resPinHi,
  input wire logic [2:0] stepResField,
  input wire logic motorDriveOn,
  input wire logic [1:0] slopeSetBits,
  input wire logic currentReachedX,
  input wire logic currentReachedY,
  input wire logic [3:0] switchOverVoltX,
  input wire logic [3:0] switchOverVoltY,
  output logic [6:0] translatorIndex_q,
  output logic [2:0] effRes_q,
  output logic [7:0] coilMagX_q,
  output logic coilNegX_q,
  output logic [7:0] coilMagY_q,
  output logic coilNegY_q,
  output logic [1:0] slopeCtrl_q,
  output logic [3:0] gateX_q,
  output logic [3:0] gateY_q,
  output logic bridgeOffX_q,
  output logic bridgeOffY_q,
  output logic [7:0] dutyX_q,
  output logic [7:0] dutyY_q,
  output logic topRegX_q,
  output logic topRegY_q,
  output logic fastDecayX_q,
  output logic fastDecayY_q,
  output logic shortX_q,
  output logic shortY_q
);
  // ***************************
  // pin synchronisers
  // ***************************
  logic [14:0] pinMeta_q;
  logic [14:0] pinSync_q;
  logic stepPrev_q;
  logic [8:0] pwmCnt_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_q <= 15'h0000;
      pinSync_q <= 15'h0000;
      stepPrev_q <= 1'b0;
    end else begin
      pinMeta_q <= {switchOverVoltY, switchOverVoltX, currentReachedY, currentReachedX,
                    resPinHi, resPinLo, runHoldIn, rotationSensePin, stepPulseIn};
      pinSync_q <= pinMeta_q;
      stepPrev_q <= pinSync_q[0];
    end
  end
  // free-running period counter; nothing outside can retune it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwmCnt_q <= 9'h000;
    end else begin
      pwmCnt_q <= pwmCnt_q + 9'h001;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slopeCtrl_q <= 2'h0;
    end else begin
      slopeCtrl_q <= slopeSetBits;
    end
  end
  // ***************************
  // translator
  // ***************************
  logic running;
  logic dirUp;
  logic stepEvent;
  logic [3:0] resSum;
  logic [2:0] res_d;
  logic [6:0] stepSize;
  logic [6:0] lowMask;
  logic [6:0] base;
  logic [6:0] idx_d;
  assign running = ctrlFromBits ? runHoldBit : pinSync_q[2];
  assign dirUp = ctrlFromBits ? rotationSenseBit : pinSync_q[1];
  assign stepEvent = running & ((pinSync_q[0] & ~stepPrev_q) | stepAdvanceCmd);
  // full-step codes above 1/2 are out of scope, so sums saturate there
  assign resSum = {1'b0, stepResField} + {2'b00, pinSync_q[4], pinSync_q[3]};
  assign res_d = (resSum > {1'b0, RES_1_2}) ? RES_1_2 : resSum[2:0];
  assign stepSize = 7'h01 << res_d;
  assign lowMask = stepSize - 7'h01;
  assign base = translatorIndex_q & ~lowMask;
  always_comb begin
    idx_d = translatorIndex_q;
    if ((translatorIndex_q & lowMask) != 7'h00) begin
      idx_d = dirUp ? base + stepSize : base;
    end else begin
      idx_d = dirUp ? translatorIndex_q + stepSize : translatorIndex_q - stepSize;
    end
  end
  // index only moves on a step, so resolution changes alone never shift it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      translatorIndex_q <= IDX_RESET;
      effRes_q <= RES_1_32;
    end else begin
      effRes_q <= res_d;
      if (stepEvent) begin
        translatorIndex_q <= idx_d;
      end
    end
  end
  // ***************************
  // index to coil currents
  // ***************************
  logic [1:0] quad;
  logic [5:0] fine;
  logic [5:0] fineRev;
  logic [7:0] magX_d;
  logic [7:0] magY_d;
  logic negX_d;
  logic negY_d;
  assign quad = translatorIndex_q[6:5];
  assign fine = {1'b0, translatorIndex_q[4:0]};
  assign fineRev = 6'h20 - fine;
  assign magX_d = smt_cos_mag(quad[0] ? fineRev : fine);
  assign magY_d = smt_cos_mag(quad[0] ? fine : fineRev);
  assign negX_d = quad[0] ^ quad[1];
  assign negY_d = quad[1];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coilMagX_q <= 8'hb4;
      coilMagY_q <= 8'hb4;
      coilNegX_q <= 1'b0;
      coilNegY_q <= 1'b0;
    end else begin
      coilMagX_q <= magX_d;
      coilMagY_q <= magY_d;
      coilNegX_q <= negX_d;
      coilNegY_q <= negY_d;
    end
  end
  // ***************************
  // bridges
  // ***************************
  smt_bridge uBridgeX (
    .clk(clk), .rstn(rstn), .enable(motorDriveOn), .setNeg(coilNegX_q),
    .lowerReq(magX_d < coilMagX_q),
    .reached(pinSync_q[5]), .overVolt(pinSync_q[10:7]), .pwmCnt(pwmCnt_q),
    .gate_q(gateX_q), .off_q(bridgeOffX_q), .duty_q(dutyX_q), .topReg_q(topRegX_q),
    .fastDecay_q(fastDecayX_q), .shortFault_q(shortX_q)
  );
  smt_bridge uBridgeY (
    .clk(clk), .rstn(rstn), .enable(motorDriveOn), .setNeg(coilNegY_q),
    .lowerReq(magY_d < coilMagY_q),
    .reached(pinSync_q[6]), .overVolt(pinSync_q[14:11]), .pwmCnt(pwmCnt_q),
    .gate_q(gateY_q), .off_q(bridgeOffY_q), .duty_q(dutyY_q), .topReg_q(topRegY_q),
    .fastDecay_q(fastDecayY_q), .shortFault_q(shortY_q)
  );
endmodule : smt_translator_pwm

/* File: testbench/smt_checker.sv */
// concurrent checks on the translator and bridge loop ports
`timescale 1ns/10ps
module smt_checker
  import smt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic stepAdvanceCmd,
  input wire logic ctrlFromBits,
  input wire logic runHoldBit,
  input wire logic rotationSenseBit,
  input wire logic [2:0] stepResField,
  input wire logic motorDriveOn,
  input wire logic [6:0] translatorIndex_q,
  input wire logic [2:0] effRes_q,
  input wire logic [7:0] coilMagX_q,
  input wire logic coilNegX_q,
  input wire logic [7:0] coilMagY_q,
  input wire logic coilNegY_q,
  input wire logic [3:0] gateX_q,
  input wire logic [3:0] gateY_q,
  input wire logic bridgeOffX_q,
  input wire logic bridgeOffY_q,
  input wire logic shortX_q,
  input wire logic topRegX_q
);
  // ***************************
  // properties
  // ***************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_interlock;
    !(gateX_q[3] && gateX_q[2]) && !(gateX_q[1] && gateX_q[0]) &&
      !(gateY_q[3] && gateY_q[2]) && !(gateY_q[1] && gateY_q[0]);
  endproperty
  a_interlock: assert property (p_interlock) else $error("half bridge both on");
  // low switch must have been off one and nine cycles before the high switch rises
  property p_dead;
    $rose(gateX_q[3]) |-> !$past(gateX_q[2]) && !$past(gateX_q[2], 9);
  endproperty
  a_dead: assert property (p_dead) else $error("high switch on too soon");
  property p_off;
    !motorDriveOn |=> gateX_q == GATE_OFF && gateY_q == GATE_OFF && bridgeOffX_q && bridgeOffY_q;
  endproperty
  a_off: assert property (p_off) else $error("bridge active while disabled");
  property p_short;
    shortX_q |=> gateX_q == GATE_OFF && bridgeOffX_q;
  endproperty
  a_short: assert property (p_short) else $error("shorted bridge still driven");
  property p_stepup;
    stepAdvanceCmd && ctrlFromBits && runHoldBit && rotationSenseBit &&
      stepResField == RES_1_32 && effRes_q == RES_1_32
      |=> translatorIndex_q == 7'($past(translatorIndex_q) + 7'h1);
  endproperty
  a_stepup: assert property (p_stepup) else $error("fine step not plus one");
  property p_hold;
    ctrlFromBits && !runHoldBit |=> $stable(translatorIndex_q);
  endproperty
  a_hold: assert property (p_hold) else $error("index moved in hold");
  property p_map0;
    translatorIndex_q == 7'h00 |=> coilMagX_q == 8'hff && !coilNegX_q && coilMagY_q == 8'h00;
  endproperty
  a_map0: assert property (p_map0) else $error("index 0 currents wrong");
  property p_map64;
    translatorIndex_q == 7'h40 |=> coilMagX_q == 8'hff && coilNegX_q && coilMagY_q == 8'h00;
  endproperty
  a_map64: assert property (p_map64) else $error("index 64 currents wrong");
  // second half of the circle drives coil y negative
  property p_signy;
    translatorIndex_q > 7'h40 |=> coilNegY_q && coilMagY_q != 8'h00;
  endproperty
  a_signy: assert property (p_signy) else $error("coil y sign wrong");

  c_step: cover property (stepAdvanceCmd && runHoldBit);
  c_short: cover property ($rose(shortX_q));
  c_top: cover property ($rose(topRegX_q));
endmodule : smt_checker

bind smt_translator_pwm smt_checker u_chk (.clk(clk), .rstn(rstn),
  .stepAdvanceCmd(stepAdvanceCmd), .ctrlFromBits(ctrlFromBits), .runHoldBit(runHoldBit),
  .rotationSenseBit(rotationSenseBit), .stepResField(stepResField),
  .motorDriveOn(motorDriveOn), .translatorIndex_q(translatorIndex_q), .effRes_q(effRes_q),
  .coilMagX_q(coilMagX_q), .coilNegX_q(coilNegX_q), .coilMagY_q(coilMagY_q),
  .coilNegY_q(coilNegY_q),
  .gateX_q(gateX_q), .gateY_q(gateY_q), .bridgeOffX_q(bridgeOffX_q),
  .bridgeOffY_q(bridgeOffY_q), .shortX_q(shortX_q), .topRegX_q(topRegX_q));

/* File: testbench/smt_step_host.sv */
// controller model that drives the step pin
`timescale 1ns/10ps
module smt_step_host (
  input wire logic clk,
  input wire logic go,
  output logic stepPulseIn,
  output logic busy
);
  // ***************************
  // one step pulse per request
  // ***************************
  initial begin
    stepPulseIn = 1'b0;
    busy = 1'b0;
  end
  always @(posedge go) begin
    busy = 1'b1;
    repeat (2500) @(negedge clk);
    stepPulseIn = 1'b1;
    repeat (200) @(negedge clk);
    stepPulseIn = 1'b0;
    repeat (200) @(negedge clk);
    busy = 1'b0;
  end
endmodule : smt_step_host

/* File: testbench/smt_translator_pwm_test.sv */
// self-checking bench for the translator and bridge loops
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module smt_translator_pwm_test import smt_pkg::*;;
  logic clk = 1'b0;
  logic rstn, stepPulseIn, stepAdvanceCmd, rotationSensePin, rotationSenseBit, ctrlFromBits;
  logic runHoldIn, runHoldBit, resPinLo, resPinHi, motorDriveOn, currentReachedX;
  logic currentReachedY, coilNegX_q, coilNegY_q, bridgeOffX_q, bridgeOffY_q, topRegX_q;
  logic topRegY_q, fastDecayX_q, fastDecayY_q, shortX_q, shortY_q, go, busy, seen, seenY;
  logic [2:0] stepResField, effRes_q;
  logic [1:0] slopeSetBits, slopeCtrl_q;
  logic [3:0] switchOverVoltX, switchOverVoltY, gateX_q, gateY_q;
  logic [6:0] translatorIndex_q;
  logic [7:0] coilMagX_q, coilMagY_q, dutyX_q, dutyY_q;
  int errors = 0;
  int n_compared = 0;
  // field, direction and expected index of each command step
  logic [2:0] tf [15] = '{3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h3, 3'h4, 3'h4, 3'h4,
    3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
  logic td [15] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0,
    1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  logic [6:0] te [15] = '{7'h10, 7'h20, 7'h28, 7'h2c, 7'h2e, 7'h2f, 7'h28, 7'h30, 7'h40,
    7'h30, 7'h20, 7'h10, 7'h00, 7'h70, 7'h00};

  always #5 clk = ~clk;
  smt_translator_pwm DUT (.*);
  smt_step_host u_host (.clk(clk), .go(go), .stepPulseIn(stepPulseIn), .busy(busy));

  // ***************************
  // tasks
  // ***************************
  task automatic results();
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // field settles first, step uses it only at the command
  task automatic step(input logic [2:0] f, input logic d);
    logic [6:0] was;
    @(negedge clk);
    was = translatorIndex_q;
    stepResField = f;
    rotationSenseBit = d;
    repeat (4) @(negedge clk);
    `CHK("idx_field", was, translatorIndex_q)
    stepAdvanceCmd = 1'b1;
    @(negedge clk);
    stepAdvanceCmd = 1'b0;
    repeat (2) @(negedge clk);
  endtask : step

  initial begin
    #200000;
    errors++;
    results();
  end

  // ***************************
  // tests
  // ***************************
  initial begin
    {rstn, stepAdvanceCmd, rotationSensePin, rotationSenseBit, runHoldIn, resPinLo} = 6'h00;
    {resPinHi, motorDriveOn, currentReachedX, currentReachedY, go} = 5'h00;
    {ctrlFromBits, runHoldBit, stepResField, slopeSetBits} = 7'h60;
    {switchOverVoltX, switchOverVoltY} = 8'h00;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    `CHK("idx_rst", IDX_RESET, translatorIndex_q)
    `CHK("magx_rst", 8'hb4, coilMagX_q)
    `CHK("magy_rst", 8'hb4, coilMagY_q)
    `CHK("off_rst", 1'b1, bridgeOffX_q)
    slopeSetBits = 2'h2;
    repeat (2) @(negedge clk);
    `CHK("slope", 2'h2, slopeCtrl_q)
    {ctrlFromBits, runHoldIn, rotationSensePin, go} = 4'h7;
    @(negedge clk);
    go = 1'b0;
    for (int i = 0; i < 4000 && busy; i++) @(negedge clk);
    `CHK("idx_pin", 7'h11, translatorIndex_q)
    {resPinHi, stepResField} = 4'h9;
    repeat (4) @(negedge clk);
    `CHK("eff_res", RES_1_4, effRes_q)
    {resPinHi, ctrlFromBits, runHoldBit} = 3'h2;
    step(RES_1_32, 1'b1);
    `CHK("idx_hold", 7'h11, translatorIndex_q)
    runHoldBit = 1'b1;
    for (int i = 0; i < 15; i++) begin
      step(tf[i], td[i]);
      `CHK("idx_tab", te[i], translatorIndex_q)
    end
    {motorDriveOn, currentReachedY} = 2'h3;
    repeat (1600) @(negedge clk);
    `CHK("gate_fwd", GATE_POS, gateX_q)
    `CHK("duty_full", 8'hff, dutyX_q)
    `CHK("top", 1'b1, topRegX_q)
    `CHK("on", 1'b0, bridgeOffX_q)
    currentReachedX = 1'b1;
    repeat (1600) @(negedge clk);
    `CHK("bottom", 1'b0, topRegX_q)
    `CHK("duty_low", 1'b1, dutyX_q < 8'h80)
    `CHK("top_y", 1'b0, topRegY_q)
    `CHK("duty_y", 1'b1, dutyY_q < 8'h80)
    {seen, seenY} = 2'h0;
    fork
      step(RES_1_8, 1'b1);
      for (int i = 0; i < 12; i++) begin
        @(negedge clk);
        seen = seen | fastDecayX_q;
        seenY = seenY | fastDecayY_q;
      end
    join
    `CHK("fast", 1'b1, seen)
    `CHK("fast_y", 1'b0, seenY)
    motorDriveOn = 1'b0;
    @(negedge clk);
    `CHK("gate_dis", GATE_OFF, gateX_q)
    `CHK("off_dis", 1'b1, bridgeOffX_q)
    step(RES_1_8, 1'b0);
    `CHK("idx_dis", 7'h00, translatorIndex_q)
    {motorDriveOn, currentReachedX} = 2'h2;
    repeat (1200) @(negedge clk);
    `CHK("gate_back", GATE_POS, gateX_q)
    // stuck overvoltage on every switch of bridge x
    switchOverVoltX = 4'hf;
    repeat (100) @(negedge clk);
    `CHK("short", 1'b1, shortX_q)
    `CHK("short_y", 1'b0, shortY_q)
    `CHK("off_short", 1'b1, bridgeOffX_q)
    {switchOverVoltX, motorDriveOn} = 5'h00;
    repeat (3) @(negedge clk);
    `CHK("short_clr", 1'b0, shortX_q)
    results();
  end
endmodule : smt_translator_pwm_test
